// *** hdl/fault_bank_pkg.sv ***
// Purpose: shared constants of the motor driver fault status bank
// Assumes: 16-bit serial frames, 6-bit register addresses, 8-bit data
// Notes: addresses are the serial register addresses, not byte addresses
package fault_bank_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_IC_STATUS = 6'h00;
    localparam logic [5:0] ADDR_THERMAL_OC = 6'h01;
    localparam logic [5:0] ADDR_SUPPLY_LINK = 6'h02;
    localparam logic [5:0] ADDR_CTRL_A = 6'h03;
    localparam logic [5:0] ADDR_CTRL_B = 6'h04;
    localparam logic [5:0] ADDR_CTRL_C = 6'h05;
    localparam logic [5:0] ADDR_CTRL_D = 6'h06;
    localparam logic [5:0] ADDR_CTRL_E = 6'h07;
    localparam logic [5:0] ADDR_CTRL_F = 6'h08;
    localparam logic [5:0] ADDR_CTRL_G = 6'h0C;
    localparam logic [5:0] ADDR_LAST = 6'h0C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_CTRL_A = 8'h00;
    localparam logic [7:0] RESET_CTRL_B = 8'h60;
    localparam logic [7:0] RESET_CTRL_C = 8'h46;
    localparam logic [7:0] RESET_CTRL_D = 8'h10;
    localparam logic [7:0] RESET_CTRL_E = 8'h00;
    localparam logic [7:0] RESET_CTRL_F = 8'h00;
    localparam logic [7:0] RESET_CTRL_G = 8'h00;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_A_MASK = 8'h07;
    localparam logic [7:0] CTRL_B_MASK = 8'hFE;
    localparam logic [7:0] CTRL_C_MASK = 8'h7F;
    localparam logic [2:0] LOCK_CODE_UNLOCK = 3'h3;
    localparam logic [2:0] LOCK_CODE_LOCK = 3'h6;
    localparam int CLEAR_FAULT_BIT = 0;
    localparam int SDO_PUSH_PULL_BIT = 5;
    localparam int THERMAL_WARN_BIT = 7;
    localparam int THERMAL_SHUT_BIT = 6;
    localparam int SUPPLY_FLAG_BITS = 7;
    localparam int IC_FAULT_BIT = 0;
    localparam int IC_OT_BIT = 1;
    localparam int IC_NPOR_BIT = 3;
    localparam int IC_OCP_BIT = 4;
    localparam int IC_LINK_BIT = 5;
    localparam int IC_BUCK_BIT = 6;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] COUNT_OVER = 5'h11;
    localparam logic [4:0] ADDR_DONE_BITS = 5'h07;
    localparam int RW_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 9;

endpackage

// *** hdl/fault_latch.sv ***
// Purpose: bank of sticky fault flags
// Assumes: set and clear come from logic on clk
// Notes: a set in the clear cycle survives the clear
`timescale 1ns/1ps
module fault_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic clear,
    output logic [WIDTH-1:0] flags
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("fault_latch needs WIDTH of at least one");
    end

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_flag
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                flags[i] <= 1'b0;
            else if (set[i])
                flags[i] <= 1'b1;
            else if (clear)
                flags[i] <= 1'b0;
        end
    end

endmodule

// *** hdl/motor_driver_fault_status_bank.sv ***
// Purpose: fault status bank and control map behind the serial link
// Assumes: link pins are asynchronous; detectors run on clk
// Notes: sleep pin low holds the control words at reset and clears the flags, but a detector set still wins
`timescale 1ns/1ps
module motor_driver_fault_status_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic chip_select_low_active,
    input wire logic sleep_pin_low_active,
    input wire logic thermal_warning_detect,
    input wire logic thermal_shutdown_detect,
    input wire logic phase_c_high_detect,
    input wire logic phase_c_low_detect,
    input wire logic phase_b_high_detect,
    input wire logic phase_b_low_detect,
    input wire logic phase_a_high_detect,
    input wire logic phase_a_low_detect,
    input wire logic otp_error_detect,
    input wire logic regulator_overcurrent_detect,
    input wire logic regulator_undervoltage_detect,
    input wire logic pump_undervoltage_detect,
    output logic sdo,
    output logic sdo_oe,
    output logic [7:0] thermal_overcurrent_status,
    output logic [7:0] supply_link_fault_status,
    output logic [7:0] control_word_a,
    output logic [7:0] control_word_b,
    output logic [7:0] control_word_c,
    output logic [7:0] control_word_d,
    output logic [7:0] control_word_e,
    output logic [7:0] control_word_f,
    output logic [7:0] control_word_g
);

    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic sclk_s;
    logic sdi_s;
    logic cs_n_s;
    logic sleep_n_s;
    logic sclk_q;
    logic cs_n_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic selected;
    logic sleep_active;

    pin_sync #(
        .WIDTH(4),
        .RESET_VALUE(4'h3)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({sclk, sdi, chip_select_low_active, sleep_pin_low_active}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[3];
    assign sdi_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign sleep_n_s = pins_s[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign cs_fall = ~cs_n_s & cs_n_q;
    assign cs_rise = cs_n_s & ~cs_n_q;
    assign selected = ~cs_n_s;
    assign sleep_active = ~sleep_n_s;

    // ------------------------------------------------------------
    // frame receive
    // ------------------------------------------------------------
    logic [15:0] rx_word;
    logic [4:0] bit_count;
    logic frame_end;
    logic len_ok;
    logic parity_ok;
    logic addr_ok;
    logic [5:0] frame_addr;
    logic do_write;
    logic frame_err_evt;
    logic parity_evt;
    logic addr_evt;

    // count saturates so an overlong frame is still caught
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_word <= 16'h0000;
            bit_count <= 5'h00;
        end
        else if (cs_fall)
        begin
            rx_word <= 16'h0000;
            bit_count <= 5'h00;
        end
        else if (selected && sclk_fall)
        begin
            rx_word <= {rx_word[14:0], sdi_s};
            if (bit_count != fault_bank_pkg::COUNT_OVER)
                bit_count <= bit_count + 5'h01;
        end
    end

    assign frame_end = cs_rise;
    assign len_ok = (bit_count == fault_bank_pkg::FRAME_BITS);
    assign parity_ok = ~^rx_word;
    assign frame_addr = rx_word[fault_bank_pkg::ADDR_MSB:
                                fault_bank_pkg::ADDR_LSB];
    assign addr_ok = (frame_addr <= fault_bank_pkg::ADDR_LAST);
    assign frame_err_evt = frame_end & ~len_ok;
    assign parity_evt = frame_end & len_ok & ~parity_ok;
    assign addr_evt = frame_end & len_ok & parity_ok & ~addr_ok;
    assign do_write = frame_end & len_ok & parity_ok & addr_ok
                      & ~rx_word[fault_bank_pkg::RW_BIT];

    // ------------------------------------------------------------
    // fault flags
    // ------------------------------------------------------------
    logic clear_cmd;
    logic clear_all;
    logic [7:0] thermal_set;
    logic [6:0] supply_set;
    logic [6:0] supply_flags;

    assign clear_all = clear_cmd | sleep_active;
    assign thermal_set = {thermal_warning_detect,
                          thermal_shutdown_detect,
                          phase_c_high_detect,
                          phase_c_low_detect,
                          phase_b_high_detect,
                          phase_b_low_detect,
                          phase_a_high_detect,
                          phase_a_low_detect};
    assign supply_set = {otp_error_detect,
                         regulator_overcurrent_detect,
                         regulator_undervoltage_detect,
                         pump_undervoltage_detect,
                         parity_evt,
                         frame_err_evt,
                         addr_evt};

    fault_latch #(
        .WIDTH(8)
    ) u_thermal_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(thermal_set),
        .clear(clear_all),
        .flags(thermal_overcurrent_status)
    );

    fault_latch #(
        .WIDTH(fault_bank_pkg::SUPPLY_FLAG_BITS)
    ) u_supply_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(supply_set),
        .clear(clear_all),
        .flags(supply_flags)
    );

    assign supply_link_fault_status = {1'b0, supply_flags};

    // ------------------------------------------------------------
    // control words
    // ------------------------------------------------------------
    logic locked;
    logic [7:0] wr_data;

    assign wr_data = rx_word[7:0];

    // lock code is taken only from a whole, valid frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            locked <= 1'b0;
            control_word_a <= fault_bank_pkg::RESET_CTRL_A;
        end
        else if (sleep_active)
        begin
            locked <= 1'b0;
            control_word_a <= fault_bank_pkg::RESET_CTRL_A;
        end
        else if (do_write && frame_addr == fault_bank_pkg::ADDR_CTRL_A)
        begin
            if (wr_data[2:0] == fault_bank_pkg::LOCK_CODE_UNLOCK)
            begin
                locked <= 1'b0;
                control_word_a <= wr_data & fault_bank_pkg::CTRL_A_MASK;
            end
            else if (wr_data[2:0] == fault_bank_pkg::LOCK_CODE_LOCK)
            begin
                locked <= 1'b1;
                control_word_a <= wr_data & fault_bank_pkg::CTRL_A_MASK;
            end
        end
    end

    // writes to 9h..Bh are dropped: no storage there
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_word_b <= fault_bank_pkg::RESET_CTRL_B;
            control_word_c <= fault_bank_pkg::RESET_CTRL_C;
            control_word_d <= fault_bank_pkg::RESET_CTRL_D;
            control_word_e <= fault_bank_pkg::RESET_CTRL_E;
            control_word_f <= fault_bank_pkg::RESET_CTRL_F;
            control_word_g <= fault_bank_pkg::RESET_CTRL_G;
        end
        else if (sleep_active)
        begin
            control_word_b <= fault_bank_pkg::RESET_CTRL_B;
            control_word_c <= fault_bank_pkg::RESET_CTRL_C;
            control_word_d <= fault_bank_pkg::RESET_CTRL_D;
            control_word_e <= fault_bank_pkg::RESET_CTRL_E;
            control_word_f <= fault_bank_pkg::RESET_CTRL_F;
            control_word_g <= fault_bank_pkg::RESET_CTRL_G;
        end
        else if (do_write && !locked)
        begin
            case (frame_addr)
                fault_bank_pkg::ADDR_CTRL_B:
                    control_word_b <= wr_data & fault_bank_pkg::CTRL_B_MASK;
                fault_bank_pkg::ADDR_CTRL_C:
                    control_word_c <= wr_data & fault_bank_pkg::CTRL_C_MASK;
                fault_bank_pkg::ADDR_CTRL_D:
                    control_word_d <= wr_data;
                fault_bank_pkg::ADDR_CTRL_E:
                    control_word_e <= wr_data;
                fault_bank_pkg::ADDR_CTRL_F:
                    control_word_f <= wr_data;
                fault_bank_pkg::ADDR_CTRL_G:
                    control_word_g <= wr_data;
                default:
                    control_word_g <= control_word_g;
            endcase
        end
    end

    // clear bit is never stored: it acts once and reads zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            clear_cmd <= 1'b0;
        else
            clear_cmd <= do_write && !locked
                         && frame_addr == fault_bank_pkg::ADDR_CTRL_B
                         && wr_data[fault_bank_pkg::CLEAR_FAULT_BIT];
    end

    // ------------------------------------------------------------
    // read path and response word
    // ------------------------------------------------------------
    logic [7:0] ic_status;
    logic [7:0] rd_data;
    logic [15:0] tx_word;
    logic low_loaded;
    logic [4:0] rise_count;
    logic [4:0] tx_index;
    logic sdo_bit;
    logic push_pull;

    always_comb
    begin
        ic_status = 8'h00;
        ic_status[fault_bank_pkg::IC_FAULT_BIT] =
            |thermal_overcurrent_status | |supply_flags;
        ic_status[fault_bank_pkg::IC_OT_BIT] =
            thermal_overcurrent_status[fault_bank_pkg::THERMAL_WARN_BIT]
            | thermal_overcurrent_status[fault_bank_pkg::THERMAL_SHUT_BIT];
        ic_status[fault_bank_pkg::IC_NPOR_BIT] = 1'b1;
        ic_status[fault_bank_pkg::IC_OCP_BIT] =
            |thermal_overcurrent_status[5:0];
        ic_status[fault_bank_pkg::IC_LINK_BIT] = |supply_flags[2:0];
        ic_status[fault_bank_pkg::IC_BUCK_BIT] = |supply_flags[5:4];
    end

    // reading is side-effect free
    always_comb
    begin
        case (rx_word[5:0])
            fault_bank_pkg::ADDR_IC_STATUS: rd_data = ic_status;
            fault_bank_pkg::ADDR_THERMAL_OC:
                rd_data = thermal_overcurrent_status;
            fault_bank_pkg::ADDR_SUPPLY_LINK:
                rd_data = supply_link_fault_status;
            fault_bank_pkg::ADDR_CTRL_A: rd_data = control_word_a;
            fault_bank_pkg::ADDR_CTRL_B: rd_data = control_word_b;
            fault_bank_pkg::ADDR_CTRL_C: rd_data = control_word_c;
            fault_bank_pkg::ADDR_CTRL_D: rd_data = control_word_d;
            fault_bank_pkg::ADDR_CTRL_E: rd_data = control_word_e;
            fault_bank_pkg::ADDR_CTRL_F: rd_data = control_word_f;
            fault_bank_pkg::ADDR_CTRL_G: rd_data = control_word_g;
            default: rd_data = 8'h00;
        endcase
    end

    // low byte is fetched once the seven command bits are in
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_word <= 16'h0000;
            low_loaded <= 1'b0;
        end
        else if (cs_fall)
        begin
            tx_word <= {ic_status, 8'h00};
            low_loaded <= 1'b0;
        end
        else if (!low_loaded && bit_count == fault_bank_pkg::ADDR_DONE_BITS)
        begin
            tx_word[7:0] <= rd_data;
            low_loaded <= 1'b1;
        end
    end

    assign tx_index = 5'h0F - rise_count;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_count <= 5'h00;
            sdo_bit <= 1'b0;
        end
        else if (cs_fall)
        begin
            rise_count <= 5'h00;
            sdo_bit <= ic_status[7];
        end
        else if (selected && sclk_rise)
        begin
            if (rise_count < fault_bank_pkg::FRAME_BITS)
            begin
                sdo_bit <= tx_word[tx_index[3:0]];
                rise_count <= rise_count + 5'h01;
            end
            else
                sdo_bit <= 1'b0;
        end
    end

    // open drain while the push-pull bit is clear: drive only the low level
    assign push_pull = control_word_b[fault_bank_pkg::SDO_PUSH_PULL_BIT];
    assign sdo = sdo_bit;
    assign sdo_oe = selected & (push_pull | ~sdo_bit);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    thermal_warn_a: assert property (
        thermal_warning_detect |=> thermal_overcurrent_status[7])
        else $error("thermal warning flag not set");
    thermal_shut_a: assert property (
        thermal_shutdown_detect |=> thermal_overcurrent_status[6])
        else $error("thermal shutdown flag not set");
    high_side_a: assert property (
        phase_b_high_detect |=> thermal_overcurrent_status[3])
        else $error("high side overcurrent flag not set");
    low_side_a: assert property (
        phase_a_low_detect |=> thermal_overcurrent_status[0])
        else $error("low side overcurrent flag not set");
    flag_hold_a: assert property (
        supply_flags[4] && !clear_all |=> supply_flags[4])
        else $error("latched flag dropped without clear");
    flag_clear_a: assert property (
        clear_all && !thermal_warning_detect
        |=> !thermal_overcurrent_status[7])
        else $error("flag survived clear");
    frame_error_a: assert property (
        cs_rise && bit_count != 5'h10 |=> supply_link_fault_status[1])
        else $error("short frame not flagged");
    addr_error_a: assert property (
        cs_rise && len_ok && parity_ok && frame_addr > 6'h0C
        |=> supply_link_fault_status[0])
        else $error("invalid address not flagged");
    parity_error_a: assert property (
        cs_rise && len_ok && ^rx_word |=> supply_link_fault_status[2])
        else $error("parity error not flagged");
    read_stable_a: assert property (
        !clear_all && thermal_set == 8'h00
        |=> $stable(thermal_overcurrent_status))
        else $error("status changed without cause");
    lock_hold_a: assert property (
        locked && !sleep_active |=> $stable(control_word_d))
        else $error("locked control word changed");

endmodule

// *** hdl/pin_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are slow against clk
// Notes: only the second stage may be read outside
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_sync needs WIDTH of at least one");
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_one <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// *** verif/link_controller.sv ***
// Purpose: serial link controller model facing the fault bank
// Assumes: six clk per sclk half period, ten clk between frames
// Notes: sdo line has a pull-up, so an undriven bit reads 1
`timescale 1ns/1ps
module link_controller (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sclk,
    output logic sdi,
    output logic chip_select_low_active
);
    logic line;
    assign line = sdo_oe ? sdo : 1'b1;
    initial
    begin
        sclk = 1'b0;
        sdi = 1'b0;
        chip_select_low_active = 1'b1;
    end
    // fewer than 16 bits makes a broken frame on purpose
    task automatic xfer(input logic [15:0] w, input int n,
        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk) chip_select_low_active <= 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            sclk <= 1'b1;
            sdi <= w[15 - i];
            repeat (6) @(posedge clk);
            rx[15 - i] = line;
            sclk <= 1'b0;
            repeat (6) @(posedge clk);
        end
        chip_select_low_active <= 1'b1;
        // sdi no longer meaningful, so do not leave the last bit
        sdi <= ~sdi;
        repeat (10) @(posedge clk);
    endtask
endmodule

// *** verif/test_motor_driver_fault_status_bank.sv ***
// Purpose: self-checking bench of the fault status bank
// Assumes: link controller model paces every frame
// Notes: detector pulses come from a fixed seed
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module test_motor_driver_fault_status_bank;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_pin_low_active = 1'b1;
    logic [11:0] det = 12'h000;
    logic sclk, sdi, chip_select_low_active, sdo, sdo_oe;
    logic [7:0] st1, st2;
    logic [7:0] cw [7];
    logic [15:0] rx;
    int e1 = 0, e2 = 0, v, seed = 26444;
    int failures = 0, comparisons = 0;
    always #5 clk = ~clk;
    motor_driver_fault_status_bank dut_u (
        .clk, .rst_n, .sclk, .sdi, .chip_select_low_active,
        .sleep_pin_low_active, .thermal_warning_detect(det[7]),
        .thermal_shutdown_detect(det[6]), .phase_c_high_detect(det[5]),
        .phase_c_low_detect(det[4]), .phase_b_high_detect(det[3]),
        .phase_b_low_detect(det[2]), .phase_a_high_detect(det[1]),
        .phase_a_low_detect(det[0]), .otp_error_detect(det[11]),
        .regulator_overcurrent_detect(det[10]),
        .regulator_undervoltage_detect(det[9]),
        .pump_undervoltage_detect(det[8]), .sdo, .sdo_oe,
        .thermal_overcurrent_status(st1), .supply_link_fault_status(st2),
        .control_word_a(cw[0]), .control_word_b(cw[1]),
        .control_word_c(cw[2]), .control_word_d(cw[3]),
        .control_word_e(cw[4]), .control_word_f(cw[5]),
        .control_word_g(cw[6])
    );
    link_controller lc_u (.clk, .sdo, .sdo_oe, .sclk, .sdi,
        .chip_select_low_active);
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic acc(logic rd, logic [5:0] a, logic [7:0] d, int n = 16,
        logic bad = 1'b0);
        logic [15:0] w;
        w = {rd, a, 1'b0, d};
        w[8] = (^w) ^ bad;
        lc_u.xfer(w, n, rx);
    endtask
    task automatic cmp;
        `CHK(st1, e1);
        `CHK(st2, e2);
    endtask
    task automatic clr;
        acc(0, 6'h04, 8'h61);
        e1 = 0;
        e2 = 0;
        cmp();
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        cmp();
        `CHK(cw[0], fault_bank_pkg::RESET_CTRL_A);
        repeat (6)
        begin
            v = $random(seed);
            @(posedge clk) det <= v[11:0];
            @(posedge clk) det <= 12'h000;
            e1 |= v & 8'hFF;
            e2 |= ((v >> 8) & 4'hF) << 3;
        end
        @(posedge clk);
        cmp();
        acc(1, 6'h02, 8'h00);
        `CHK(rx[7:0], e2);
        clr();
        // one detector at a time pins each flag to its bit
        for (int b = 0; b < 12; b++)
        begin
            @(posedge clk) det <= 12'(1 << b);
            @(posedge clk) det <= 12'h000;
            if (b < 8)
                e1 = 1 << b;
            else
                e2 = 1 << (b - 5);
            acc(1, b < 8 ? 6'h01 : 6'h02, 8'h00);
            `CHK(rx[7:0], b < 8 ? e1 : e2);
            cmp();
            clr();
        end
        acc(1, 6'h01, 8'h00, 16, 1'b1);
        e2 = 4;
        cmp();
        acc(1, 6'h01, 8'h00, 8);
        e2 = 6;
        cmp();
        acc(1, 6'h0D, 8'h00);
        e2 = 7;
        cmp();
        acc(0, 6'h3F, 8'h00);
        acc(0, 6'h02, 8'h00);
        cmp();
        clr();
        acc(0, 6'h03, 8'h06);
        `CHK(cw[0], 8'h06);
        acc(0, 6'h05, 8'h11);
        `CHK(cw[2], fault_bank_pkg::RESET_CTRL_C);
        acc(0, 6'h03, 8'h03);
        `CHK(cw[0], 8'h03);
        acc(0, 6'h05, 8'h91);
        `CHK(cw[2], 8'h11);
        for (int k = 3; k < 7; k++)
        begin
            v = $random(seed);
            // only mapped control words are written here
            acc(0, k == 6 ? 6'h0C : 6'(k + 3), v[7:0]);
            acc(1, k == 6 ? 6'h0C : 6'(k + 3), 8'h00);
            `CHK(rx[7:0], v[7:0]);
            `CHK(cw[k], v[7:0]);
        end
        @(posedge clk) det <= 12'hFFF;
        @(posedge clk) det <= 12'h000;
        sleep_pin_low_active <= 1'b0;
        repeat (6) @(posedge clk);
        sleep_pin_low_active <= 1'b1;
        repeat (6) @(posedge clk);
        e1 = 0;
        e2 = 0;
        cmp();
        `CHK(cw[3], fault_bank_pkg::RESET_CTRL_D);
        test_done();
    end
    initial
    begin
        #400000;
        failures++;
        test_done();
    end
endmodule
